/* File: hdl/sync_serial1_pin_routing.sv */
// Pin router for the second synchronous serial channel on ports 4 and 8.
// Assumes pin inputs are synchronous to clk and the bench resolves pin wires
// from the output enables.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module sync_serial1_pin_routing
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire sync_serial1_pin_routing_pkg::axiReq_type axiReq,
  output sync_serial1_pin_routing_pkg::axiRsp_type axiRsp,
  // Serial channel side
  input wire sync_serial1_pin_routing_pkg::serialToPins_type serialTx,
  output sync_serial1_pin_routing_pkg::pinsToSerial_type serialRx,
  // Port 4 pins
  input wire logic [sync_serial1_pin_routing_pkg::P4_W-1:0] port4In,
  output logic [sync_serial1_pin_routing_pkg::P4_W-1:0] port4Out,
  output logic [sync_serial1_pin_routing_pkg::P4_W-1:0] port4Oe,
  // Port 8 pins
  input wire logic [sync_serial1_pin_routing_pkg::P8_W-1:0] port8In,
  output logic [sync_serial1_pin_routing_pkg::P8_W-1:0] port8Out,
  output logic [sync_serial1_pin_routing_pkg::P8_W-1:0] port8Oe
);

  sync_serial1_pin_routing_pkg::state_type state_r;
  sync_serial1_pin_routing_pkg::state_type state_nxt;
  logic awTake;
  logic wTake;
  logic arTake;
  logic [sync_serial1_pin_routing_pkg::NUM_REGS-1:0][7:0] readView;
  logic [7:0] p8Route;
  logic [3:0] p4Route;

  // Word-aligned address to register slot; hit is low for unmapped words
  function automatic logic [4:0] decode(input logic [sync_serial1_pin_routing_pkg::ADDR_W-1:0] a);
    logic [4:0] res;
    res = 5'h00;
    for (int k = 0; k < sync_serial1_pin_routing_pkg::NUM_REGS; k++)
    begin
      if (a[sync_serial1_pin_routing_pkg::ADDR_W-1:2]
          == sync_serial1_pin_routing_pkg::REG_INDEX[k])
      begin
        res = {1'b1, k[3:0]};
      end
    end
    return res;
  endfunction

  // Output enable of one pin from direction, drive code and value to drive
  function automatic logic pinEnable(input logic dir, input logic [1:0] drv, input logic val);
    logic en;
    en = 1'b0;
    if (!dir)
    begin
      if (drv == sync_serial1_pin_routing_pkg::DRIVE_CMOS)
      begin
        en = 1'b1;
      end
      // Open drain: the pin is only ever pulled low, never driven high
      else if (drv != sync_serial1_pin_routing_pkg::DRIVE_OFF)
      begin
        en = !val;
      end
    end
    return en;
  endfunction

  // Handshake outputs follow the state directly
  always_comb
  begin
    axiRsp.awready = (state_r.wrState == sync_serial1_pin_routing_pkg::WR_IDLE)
                     && !state_r.awHeld;
    axiRsp.wready = (state_r.wrState == sync_serial1_pin_routing_pkg::WR_IDLE)
                    && !state_r.wHeld;
    axiRsp.bvalid = (state_r.wrState == sync_serial1_pin_routing_pkg::WR_RESP);
    axiRsp.bresp = state_r.bresp;
    axiRsp.arready = (state_r.rdState == sync_serial1_pin_routing_pkg::RD_IDLE);
    axiRsp.rvalid = (state_r.rdState == sync_serial1_pin_routing_pkg::RD_DATA);
    axiRsp.rdata = state_r.rdata;
    axiRsp.rresp = state_r.rresp;
  end

  // A channel moves an item where its valid meets its ready
  assign awTake = axiRsp.awready && axiReq.awvalid;
  assign wTake = axiRsp.wready && axiReq.wvalid;
  assign arTake = axiRsp.arready && axiReq.arvalid;

  // Data registers read back the pin level on input pins, stored value elsewhere
  always_comb
  begin
    for (int k = 0; k < sync_serial1_pin_routing_pkg::NUM_REGS; k++)
    begin
      readView[k] = state_r.regs[k] & sync_serial1_pin_routing_pkg::REG_MASK[k];
    end
    readView[sync_serial1_pin_routing_pkg::SLOT_P4_DATA] =
      ((state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P4_DATA]
        & ~state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P4_DIR])
       | ({4'h0, port4In} & state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P4_DIR]))
      & sync_serial1_pin_routing_pkg::REG_MASK[sync_serial1_pin_routing_pkg::SLOT_P4_DATA];
    readView[sync_serial1_pin_routing_pkg::SLOT_P8_DATA] =
      (state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P8_DATA]
       & ~state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P8_DIR])
      | (port8In & state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P8_DIR]);
  end

  // Bus slave: address and data are caught in either order, the write lands
  // on the edge that completes the pair, and the response follows one cycle later
  always_comb
  begin
    logic haveAw;
    logic haveW;
    logic [sync_serial1_pin_routing_pkg::ADDR_W-1:0] wrAddr;
    logic [7:0] wrData;
    logic wrStrb;
    logic [4:0] hitW;
    logic [4:0] hitR;
    haveAw = 1'b0;
    haveW = 1'b0;
    wrAddr = '0;
    wrData = 8'h00;
    wrStrb = 1'b0;
    hitW = 5'h00;
    hitR = 5'h00;
    state_nxt = state_r;
    case (state_r.wrState)
      sync_serial1_pin_routing_pkg::WR_IDLE:
      begin
        haveAw = state_r.awHeld || awTake;
        haveW = state_r.wHeld || wTake;
        wrAddr = state_r.awHeld ? state_r.awAddr : axiReq.awaddr;
        wrData = state_r.wHeld ? state_r.wData : axiReq.wdata[7:0];
        wrStrb = state_r.wHeld ? state_r.wStrb : axiReq.wstrb[0];
        if (haveAw && haveW)
        begin
          hitW = decode(wrAddr);
          if (hitW[4] && wrStrb)
          begin
            state_nxt.regs[hitW[3:0]] = wrData & sync_serial1_pin_routing_pkg::REG_MASK[hitW[3:0]];
          end
          state_nxt.bresp = hitW[4] ? sync_serial1_pin_routing_pkg::RESP_OKAY
                                    : sync_serial1_pin_routing_pkg::RESP_SLVERR;
          state_nxt.awHeld = 1'b0;
          state_nxt.wHeld = 1'b0;
          state_nxt.wrState = sync_serial1_pin_routing_pkg::WR_RESP;
        end
        else
        begin
          state_nxt.awHeld = haveAw;
          state_nxt.awAddr = wrAddr;
          state_nxt.wHeld = haveW;
          state_nxt.wData = wrData;
          state_nxt.wStrb = wrStrb;
        end
      end
      sync_serial1_pin_routing_pkg::WR_RESP:
      begin
        if (axiReq.bready)
        begin
          state_nxt.wrState = sync_serial1_pin_routing_pkg::WR_IDLE;
        end
      end
      default:
      begin
        state_nxt.wrState = sync_serial1_pin_routing_pkg::WR_IDLE;
      end
    endcase
    // Read side is independent of the write side
    case (state_r.rdState)
      sync_serial1_pin_routing_pkg::RD_IDLE:
      begin
        if (arTake)
        begin
          hitR = decode(axiReq.araddr);
          state_nxt.rdata = hitR[4] ? {24'h000000, readView[hitR[3:0]]} : 32'h00000000;
          state_nxt.rresp = hitR[4] ? sync_serial1_pin_routing_pkg::RESP_OKAY
                                    : sync_serial1_pin_routing_pkg::RESP_SLVERR;
          state_nxt.rdState = sync_serial1_pin_routing_pkg::RD_DATA;
        end
      end
      sync_serial1_pin_routing_pkg::RD_DATA:
      begin
        if (axiReq.rready)
        begin
          state_nxt.rdState = sync_serial1_pin_routing_pkg::RD_IDLE;
        end
      end
      default:
      begin
        state_nxt.rdState = sync_serial1_pin_routing_pkg::RD_IDLE;
      end
    endcase
  end

  // Single state register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= '{regs: {sync_serial1_pin_routing_pkg::NUM_REGS{
                     sync_serial1_pin_routing_pkg::REG_RESET}},
                   wrState: sync_serial1_pin_routing_pkg::WR_IDLE,
                   rdState: sync_serial1_pin_routing_pkg::RD_IDLE, awHeld: 1'b0, awAddr: '0,
                   wHeld: 1'b0, wData: 8'h00, wStrb: 1'b0, bresp: 2'h0,
                   rdata: 32'h00000000, rresp: 2'h0};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Per-pin serial selection from the two function bits
  always_comb
  begin
    for (int i = 0; i < sync_serial1_pin_routing_pkg::P8_W; i++)
    begin
      p8Route[i] = ({state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P8_MOD1][i],
                     state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P8_MOD0][i]}
                    == sync_serial1_pin_routing_pkg::FUNC_TERTIARY)
                   && (i >= sync_serial1_pin_routing_pkg::P8_SIN_BIT)
                   && (i <= sync_serial1_pin_routing_pkg::P8_SOUT_BIT);
    end
    for (int i = 0; i < sync_serial1_pin_routing_pkg::P4_W; i++)
    begin
      p4Route[i] = ({state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P4_MOD1][i],
                     state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P4_MOD0][i]}
                    == sync_serial1_pin_routing_pkg::FUNC_SECONDARY)
                   && (i <= sync_serial1_pin_routing_pkg::P4_SOUT_BIT);
    end
  end

  // Pin drivers; routed pins ignore the data register, the serial input pin
  // drives low if software wrongly makes it an output
  always_comb
  begin
    logic v;
    v = 1'b0;
    for (int i = 0; i < sync_serial1_pin_routing_pkg::P8_W; i++)
    begin
      v = state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P8_DATA][i];
      if (p8Route[i])
      begin
        v = (i == sync_serial1_pin_routing_pkg::P8_SOUT_BIT) ? serialTx.dataOut :
            (i == sync_serial1_pin_routing_pkg::P8_SCK_BIT) ? serialTx.clockOut : 1'b0;
      end
      port8Out[i] = v;
      port8Oe[i] = pinEnable(state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P8_DIR][i],
                             {state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P8_CON1][i],
                              state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P8_CON0][i]}, v)
                   && !(p8Route[i] && (i == sync_serial1_pin_routing_pkg::P8_SCK_BIT)
                        && !serialTx.masterRole);
    end
    for (int i = 0; i < sync_serial1_pin_routing_pkg::P4_W; i++)
    begin
      v = state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P4_DATA][i];
      if (p4Route[i])
      begin
        v = (i == sync_serial1_pin_routing_pkg::P4_SOUT_BIT) ? serialTx.dataOut :
            (i == sync_serial1_pin_routing_pkg::P4_SCK_BIT) ? serialTx.clockOut : 1'b0;
      end
      port4Out[i] = v;
      port4Oe[i] = pinEnable(state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P4_DIR][i],
                             {state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P4_CON1][i],
                              state_r.regs[sync_serial1_pin_routing_pkg::SLOT_P4_CON0][i]}, v)
                   && !(p4Route[i] && (i == sync_serial1_pin_routing_pkg::P4_SCK_BIT)
                        && !serialTx.masterRole);
    end
  end

  // Serial inputs; port 8 wins if both groups are routed, idle high when neither
  always_comb
  begin
    serialRx.dataIn = p8Route[sync_serial1_pin_routing_pkg::P8_SIN_BIT] ?
                      port8In[sync_serial1_pin_routing_pkg::P8_SIN_BIT] :
                      p4Route[sync_serial1_pin_routing_pkg::P4_SIN_BIT] ?
                      port4In[sync_serial1_pin_routing_pkg::P4_SIN_BIT] :
                      sync_serial1_pin_routing_pkg::SERIAL_IDLE;
    serialRx.clockIn = p8Route[sync_serial1_pin_routing_pkg::P8_SCK_BIT] ?
                       port8In[sync_serial1_pin_routing_pkg::P8_SCK_BIT] :
                       p4Route[sync_serial1_pin_routing_pkg::P4_SCK_BIT] ?
                       port4In[sync_serial1_pin_routing_pkg::P4_SCK_BIT] :
                       sync_serial1_pin_routing_pkg::SERIAL_IDLE;
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_p8_sout_route: assert property (p8Route[6] |-> port8Out[6] == serialTx.dataOut)
    else $error("port 8 data out pin not carrying serial data");
  chk_p8_sin_route: assert property (p8Route[4] |-> serialRx.dataIn == port8In[4])
    else $error("port 8 data in pin not routed to channel");
  chk_p4_sout_route: assert property (
      (p4Route[2] |-> port4Out[2] == serialTx.dataOut)
      and (p4Route[0] && !p8Route[4] |-> serialRx.dataIn == port4In[0]))
    else $error("port 4 serial routing wrong");
  chk_input_no_drive: assert property (
      (state_r.regs[7] != 8'h00 || state_r.regs[1] != 8'h00)
      |-> ((port8Oe & state_r.regs[7]) == 8'h00)
          && ((port4Oe & state_r.regs[1][3:0]) == 4'h0))
    else $error("input pin is driven");
  chk_cmos_drive: assert property (
      !state_r.regs[7][6] && state_r.regs[9][6] && state_r.regs[8][6] |-> port8Oe[6])
    else $error("push-pull pin not driven");
  chk_p8_data_ignored: assert property (
      p8Route[6] && $changed(state_r.regs[6]) && $stable(serialTx.dataOut)
      && $stable(p8Route[6]) |-> $stable(port8Out[6]))
    else $error("port 8 data register reaches routed pin");
  chk_p4_data_ignored: assert property (
      p4Route[2] && $changed(state_r.regs[0]) && $stable(serialTx.dataOut)
      && $stable(p4Route[2]) |-> $stable(port4Out[2]))
    else $error("port 4 data register reaches routed pin");
  chk_slave_clock_in: assert property (
      p8Route[5] && !serialTx.masterRole |-> !port8Oe[5] && serialRx.clockIn == port8In[5])
    else $error("slave clock pin driven or not sampled");
  chk_master_clock_out: assert property (
      p4Route[1] && serialTx.masterRole && !state_r.regs[1][1]
      && state_r.regs[3][1] && state_r.regs[2][1]
      |-> port4Oe[1] && port4Out[1] == serialTx.clockOut)
    else $error("master clock not driven on port 4");
  // Bus timing: each answer comes one cycle after its request and holds until taken
  chk_read_latency: assert property (arTake |=> axiRsp.rvalid)
    else $error("read answer not one cycle after address");
  chk_rvalid_hold: assert property (
      axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
    else $error("read data dropped before taken");
  chk_write_latency: assert property (
      (awTake || state_r.awHeld) && (wTake || state_r.wHeld) |=> axiRsp.bvalid)
    else $error("write answer not one cycle after address and data");
  chk_bvalid_hold: assert property (
      axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
    else $error("write response dropped before taken");

  // Main scenarios, each to be seen at least once
  cov_p8_master: cover property (p8Route[6] && p8Route[5] && serialTx.masterRole && port8Oe[5]);
  cov_p8_slave: cover property (p8Route[5] && !serialTx.masterRole && !port8Oe[5]);
  cov_p4_master: cover property (p4Route[2] && p4Route[1] && serialTx.masterRole && port4Oe[1]);
  cov_bad_write: cover property (axiRsp.bvalid && axiRsp.bresp == 2'h2);
  cov_open_drain: cover property (!state_r.regs[1][2] && (state_r.regs[3][2] != state_r.regs[2][2]));

endmodule

`default_nettype wire

/* File: inc/sync_serial1_pin_routing_pkg.sv */
// Constants, register index map and carrier types for the serial pin router.
// Assumes a single 40 MHz clock domain and an AXI4-Lite master with 32-bit data.
package sync_serial1_pin_routing_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int NUM_REGS = 12;
  localparam int P4_W = 4;
  localparam int P8_W = 8;

  // Register slots, in the order of the index table below
  localparam int SLOT_P4_DATA = 0;
  localparam int SLOT_P4_DIR = 1;
  localparam int SLOT_P4_CON0 = 2;
  localparam int SLOT_P4_CON1 = 3;
  localparam int SLOT_P4_MOD0 = 4;
  localparam int SLOT_P4_MOD1 = 5;
  localparam int SLOT_P8_DATA = 6;
  localparam int SLOT_P8_DIR = 7;
  localparam int SLOT_P8_CON0 = 8;
  localparam int SLOT_P8_CON1 = 9;
  localparam int SLOT_P8_MOD0 = 10;
  localparam int SLOT_P8_MOD1 = 11;

  // Register index; byte address is four times the index
  localparam logic [15:0] REG_INDEX [NUM_REGS] = '{
    16'hF220, 16'hF221, 16'hF222, 16'hF223, 16'hF224, 16'hF225,
    16'hF240, 16'hF241, 16'hF242, 16'hF243, 16'hF244, 16'hF245};
  // Implemented bits per register; absent bits read as zero
  localparam logic [7:0] REG_MASK [NUM_REGS] = '{
    8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h07, 8'h07,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] REG_RESET = 8'h00;

  // Serial pin positions
  localparam int P8_SOUT_BIT = 6;
  localparam int P8_SCK_BIT = 5;
  localparam int P8_SIN_BIT = 4;
  localparam int P4_SOUT_BIT = 2;
  localparam int P4_SCK_BIT = 1;
  localparam int P4_SIN_BIT = 0;

  // Codes written as {high bit, low bit}
  localparam logic [1:0] FUNC_SECONDARY = 2'h1;
  localparam logic [1:0] FUNC_TERTIARY = 2'h2;
  localparam logic [1:0] DRIVE_CMOS = 2'h3;
  localparam logic [1:0] DRIVE_OFF = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic SERIAL_IDLE = 1'h1;

  typedef enum logic [0:0] {WR_IDLE, WR_RESP} wrState_type;
  typedef enum logic [0:0] {RD_IDLE, RD_DATA} rdState_type;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W/8-1:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axiReq_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axiRsp_type;

  typedef struct packed {
    logic dataOut;
    logic clockOut;
    logic masterRole;
  } serialToPins_type;

  typedef struct packed {
    logic dataIn;
    logic clockIn;
  } pinsToSerial_type;

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    wrState_type wrState;
    rdState_type rdState;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [7:0] wData;
    logic wStrb;
    logic [1:0] bresp;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } state_type;

endpackage

/* File: verif/serial_pin_partner.sv */
// Outside circuit on the port pins: each pin shows the router's level where it drives,
// otherwise whatever the attached circuit drives. Assumes the bench supplies those levels.
`timescale 1ns/1ps
`default_nettype none

module serial_pin_partner
(
  // Router pin side
  input wire logic [3:0] port4Out,
  input wire logic [3:0] port4Oe,
  input wire logic [7:0] port8Out,
  input wire logic [7:0] port8Oe,
  // Levels forced by the outside circuit, changed by the bench every cycle of a pin step
  input wire logic [3:0] ext4,
  input wire logic [7:0] ext8,
  // Resolved pin levels
  output logic [3:0] port4In,
  output logic [7:0] port8In
);
  // Router wins where it drives; a released pin never keeps the router's last value
  assign port4In = (port4Oe & port4Out) | (~port4Oe & ext4);
  assign port8In = (port8Oe & port8Out) | (~port8Oe & ext8);
endmodule

`default_nettype wire

/* File: verif/tb_sync_serial1_pin_routing.sv */
// Bench for the serial pin router: bus master, pin stimulus and a queue-fed monitor.
// Assumes the router and the pin partner model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module tb_sync_serial1_pin_routing;
  typedef struct packed {
    logic [7:0] o8;
    logic [7:0] e8;
    logic [3:0] o4;
    logic [3:0] e4;
    logic [1:0] rx;
    logic [1:0] rxm;
  } pinExp_type;
  localparam int BASE4 = sync_serial1_pin_routing_pkg::SLOT_P4_DATA;
  localparam int BASE8 = sync_serial1_pin_routing_pkg::SLOT_P8_DATA;
  localparam logic [1:0] OK = sync_serial1_pin_routing_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = sync_serial1_pin_routing_pkg::RESP_SLVERR;
  logic clk;
  logic rst_b;
  sync_serial1_pin_routing_pkg::axiReq_type req;
  sync_serial1_pin_routing_pkg::axiRsp_type rsp;
  sync_serial1_pin_routing_pkg::serialToPins_type sTx;
  sync_serial1_pin_routing_pkg::pinsToSerial_type sRx;
  logic [3:0] p4In, p4Out, p4Oe, ext4, dat4;
  logic [7:0] p8In, p8Out, p8Oe, ext8;
  logic pinStrobe;
  logic [33:0] rNote;
  pinExp_type pNote;
  logic [1:0] bQ[$];
  logic [33:0] rQ[$];
  pinExp_type pQ[$];
  int mismatches, nChecks, cycles;
  integer seed = 32'hC953;

  sync_serial1_pin_routing i_sync_serial1_pin_routing
  (
    .clk(clk), .rst_b(rst_b), .axiReq(req), .axiRsp(rsp), .serialTx(sTx), .serialRx(sRx),
    .port4In(p4In), .port4Out(p4Out), .port4Oe(p4Oe),
    .port8In(p8In), .port8Out(p8Out), .port8Oe(p8Oe)
  );
  serial_pin_partner i_serial_pin_partner
  (
    .port4Out(p4Out), .port4Oe(p4Oe), .port8Out(p8Out), .port8Oe(p8Oe),
    .ext4(ext4), .ext8(ext8), .port4In(p4In), .port8In(p8In)
  );

  // Free-running 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [15:0] ix(input int s);
    return sync_serial1_pin_routing_pkg::REG_INDEX[s];
  endfunction

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && nChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Address and data offered together; each released on its own ready, then the response
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    logic tA, tW, tB;
    logic [31:0] r;
    bQ.push_back(er);
    r = $random(seed);
    @(posedge clk);
    req.awaddr <= {a, 2'h0};
    req.wdata <= {r[23:0], d};
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(negedge clk);
      tA = req.awvalid && rsp.awready;
      tW = req.wvalid && rsp.wready;
      tB = rsp.bvalid;
      @(posedge clk);
      if (tA) req.awvalid <= 1'b0;
      if (tW) req.wvalid <= 1'b0;
      if (tB) req.bready <= 1'b0;
    end
    while (!tB);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    logic tA, tR;
    rQ.push_back({er, 24'h0, d});
    @(posedge clk);
    req.araddr <= {a, 2'h0};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(negedge clk);
      tA = req.arvalid && rsp.arready;
      tR = rsp.rvalid;
      @(posedge clk);
      if (tA) req.arvalid <= 1'b0;
      if (tR) req.rready <= 1'b0;
    end
    while (!tR);
  endtask

  task automatic cfg(input int p, input logic [7:0] dir, con, m0, m1, dat);
    wr(ix(p + 5), m1, OK);
    wr(ix(p + 4), m0, OK);
    wr(ix(p + 3), con, OK);
    wr(ix(p + 2), con, OK);
    wr(ix(p + 1), dir, OK);
    wr(ix(p), dat, OK);
  endtask

  // Random channel and outside levels each cycle; g 8 or 4 routed group, 1 plain port,
  // 2 plain port with pin 2 open drain, 0 none
  task automatic step(input int g, input logic m, input int n);
    logic [31:0] r;
    pinExp_type e;
    repeat (n)
    begin
      @(posedge clk);
      r = $random(seed);
      e = '0;
      e.rx = 2'h3;
      e.rxm = 2'h3;
      if (g == 8) e.e8 = m ? 8'h60 : 8'h40;
      if (g == 8) e.o8 = {1'b0, r[0], m & r[1], 5'h0};
      if (g == 8) e.rx = {r[12], r[13]};
      if (g == 4) e.e4 = m ? 4'h6 : 4'h4;
      if (g == 4) e.o4 = {1'b0, r[0], m & r[1], 1'b0};
      if (g == 4) e.rx = {r[16], r[17]};
      if (g == 1) e.e4 = 4'h4;
      if (g == 1) e.o4 = {1'b0, dat4[2], 2'h0};
      if (g == 2) e.e4 = {1'b0, !dat4[2], 2'h0};
      if (g > 1) e.rxm = {1'b1, !m};
      e.rx = e.rx & e.rxm;
      sTx <= {r[0], r[1], m};
      ext8 <= r[15:8];
      ext4 <= r[19:16];
      pinStrobe <= 1'b1;
      pQ.push_back(e);
    end
    @(posedge clk);
    pinStrobe <= 1'b0;
  endtask

  // Monitor: mid-cycle, when a result stands, the oldest note is taken and compared
  always @(negedge clk)
  begin
    if (rst_b && rsp.bvalid && req.bready)
      cmp("bresp", 32'(bQ.pop_front()), 32'(rsp.bresp));
    if (rst_b && rsp.rvalid && req.rready)
    begin
      rNote = rQ.pop_front();
      cmp("rdata", rNote[31:0], rsp.rdata);
      cmp("rresp", 32'(rNote[33:32]), 32'(rsp.rresp));
    end
    if (pinStrobe)
    begin
      pNote = pQ.pop_front();
      cmp("port8Oe", 32'(pNote.e8), 32'(p8Oe));
      cmp("port8Out", 32'(pNote.o8), 32'(p8Out & pNote.e8));
      cmp("port4Oe", 32'(pNote.e4), 32'(p4Oe));
      cmp("port4Out", 32'(pNote.o4), 32'(p4Out & pNote.e4));
      cmp("serialRx", 32'(pNote.rx), 32'(sRx & pNote.rxm));
    end
  end

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      summarize();
    end
  end

  initial
  begin
    logic m;
    logic [31:0] r;
    req = '0;
    sTx = '0;
    ext4 = 4'h5;
    ext8 = 8'hA5;
    dat4 = 4'h0;
    pinStrobe = 1'b0;
    rst_b = 1'b0;
    mismatches = 0;
    nChecks = 0;
    cycles = 0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    step(0, 1'b0, 2);
    // Reset values, then every implemented bit set; input pins read their level
    for (int i = 0; i < 12; i++)
      rd(ix(i), 8'h00, OK);
    for (int i = 0; i < 12; i++)
      wr(ix(i), 8'hFF, OK);
    for (int i = 0; i < 12; i++)
      rd(ix(i), i == BASE4 ? {4'h0, ext4} : i == BASE8 ? ext8 :
        sync_serial1_pin_routing_pkg::REG_MASK[i], OK);
    step(0, 1'b1, 2);
    wr(16'hF230, 8'h5A, ERR);
    rd(16'hF230, 8'h00, ERR);
    // Each group in master then slave role, with random data and optional input drive
    for (int k = 0; k < 4; k++)
    begin
      m = !k[0];
      r = $random(seed);
      if (k == 2) cfg(BASE8, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00);
      if (k < 2) cfg(BASE8, m ? 8'h10 : 8'h30, (m ? 8'h60 : 8'h40) |
        (r[7:0] & (m ? 8'h10 : 8'h30)), 8'h00, 8'h70, r[15:8]);
      dat4 = r[11:8];
      if (k > 1) cfg(BASE4, m ? 8'h01 : 8'h03, (m ? 8'h06 : 8'h04) |
        (r[7:0] & (m ? 8'h01 : 8'h03)), 8'h07, 8'h00, {4'h0, dat4});
      step(k < 2 ? 8 : 4, m, 6);
    end
    // Port 4 back to plain port: the data register drives the push-pull pin again
    wr(ix(BASE4 + 4), 8'h00, OK);
    step(1, 1'b0, 3);
    // Drive code with only the high bit set: the pin can only pull low
    wr(ix(BASE4 + 2), 8'h03, OK);
    step(2, 1'b0, 2);
    summarize();
  end
endmodule

`default_nettype wire
